// *** rtl/factory_info_pkg.sv ***
package factory_info_pkg;

  // Width of one program word.
  localparam int WORD_W = 14;
  // Number of words in each group of the information area.
  localparam int SERIAL_N = 9;
  localparam int CUST_N = 8;
  localparam int TCAL_N = 3;
  localparam int REF_N = 3;

  // Bounds of the information area and of its groups.
  localparam logic [15:0] INFO_BASE = 16'h8100;
  localparam logic [15:0] INFO_LAST = 16'h813F;
  localparam logic [15:0] SERIAL_BASE = 16'h8100;
  localparam logic [15:0] SERIAL_LAST = 16'h8108;
  localparam logic [15:0] CUST_BASE = 16'h810A;
  localparam logic [15:0] CUST_LAST = 16'h8111;
  localparam logic [15:0] TLOW_BASE = 16'h8112;
  localparam logic [15:0] TLOW_LAST = 16'h8114;
  localparam logic [15:0] THIGH_BASE = 16'h8115;
  localparam logic [15:0] THIGH_LAST = 16'h8117;
  localparam logic [15:0] ADC_REF_BASE = 16'h8118;
  localparam logic [15:0] ADC_REF_LAST = 16'h811A;
  localparam logic [15:0] CMP_REF_BASE = 16'h811B;
  localparam logic [15:0] CMP_REF_LAST = 16'h811D;

  // Bounds of the geometry block and its word positions.
  localparam logic [15:0] GEOM_BASE = 16'h8200;
  localparam logic [15:0] GEOM_LAST = 16'h8204;
  localparam logic [2:0] ERASE_ROW_OFS = 3'h0;
  localparam logic [2:0] WRITE_LATCH_OFS = 3'h1;
  localparam logic [2:0] ERASABLE_ROW_OFS = 3'h2;
  localparam logic [2:0] EEPROM_SIZE_OFS = 3'h3;
  localparam logic [2:0] PIN_TOTAL_OFS = 3'h4;

  // Erasable row counts of the two memory variants.
  localparam logic [13:0] ROWS_SMALL = 14'h0080;
  localparam logic [13:0] ROWS_LARGE = 14'h0100;

  // Answer for reserved words inside either range.
  localparam logic [13:0] RESERVED_WORD = 14'h3FFF;

  typedef logic [WORD_W-1:0] word_t;

  // Decoded region of a read address.
  typedef enum logic [3:0] {
    REG_NONE, REG_SERIAL, REG_RESERVED, REG_CUSTOMER, REG_TLOW,
    REG_THIGH, REG_ADC_REF, REG_CMP_REF, REG_GEOM
  } region_e;

  // Kinds of program-memory modification requests.
  typedef enum logic [1:0] {PROG_WRITE, PROG_ROW_ERASE, PROG_BULK_ERASE} prog_kind_e;

  typedef struct packed {
    logic [15:0] addr;
  } read_req_s;

  typedef struct packed {
    word_t data;
    logic hit;
  } read_rsp_s;

  typedef struct packed {
    prog_kind_e kind;
    logic [15:0] addr;
  } prog_req_s;

endpackage

// *** rtl/factory_info_rom.sv ***
`timescale 1ns/1ns
// Operation
// - Information area is a read-only window from 8100h to 813Fh.
// - Nine serial words sit at 8100h to 8108h and form one identifier.
// - No erase or write path changes the serial words.
// - Customer identifier words sit at 810Ah to 8111h, set at manufacture.
// - Bulk erase leaves the customer identifier words intact.
// - Low-range temperature gain, 90 degree reading and offset at 8112h to 8114h.
// - High-range temperature gain, 90 degree reading and offset at 8115h to 8117h.
// - Reference voltages in mV for 1x, 2x, 4x, converter then comparator.
// - Geometry block is read-only; writes and erases never alter it.
// - Geometry words: row size, latches, rows, EEPROM bytes, pins at 8200h to 8204h.
// - Erasable row count reads 128 on the small variant, 256 on the large.
// - Programming and debug tools read both regions like any other reader.
module factory_info_rom
  import factory_info_pkg::*;
#(
  parameter logic [SERIAL_N*WORD_W-1:0] SERIAL_INIT = '0,
  parameter logic [CUST_N*WORD_W-1:0] CUST_INIT = '0,
  parameter logic [TCAL_N*WORD_W-1:0] TLOW_INIT = '0,
  parameter logic [TCAL_N*WORD_W-1:0] THIGH_INIT = '0,
  parameter logic [REF_N*WORD_W-1:0] ADC_REF_INIT = '0,
  parameter logic [REF_N*WORD_W-1:0] CMP_REF_INIT = '0,
  parameter logic [WORD_W-1:0] ERASE_ROW_WORDS = 14'h0020,
  parameter logic [WORD_W-1:0] WRITE_LATCH_WORDS = 14'h0020,
  parameter logic [WORD_W-1:0] EEPROM_BYTES = 14'h0080,
  parameter logic [WORD_W-1:0] PIN_TOTAL = 14'h001C,
  parameter bit LARGE_VARIANT = 1'b0
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rstn,
  // Read port shared by the memory controller and external tools.
  input wire logic rd_req,
  input wire read_req_s rd_cmd,
  output logic rd_valid,
  output read_rsp_s rd_rsp,
  // Modification requests seen by the protected ranges.
  input wire logic prog_req,
  input wire prog_req_s prog_cmd,
  output logic prog_err
);

  ////////////////////////////////////////////////////////////////////////////
  // Elaboration checks.

  // The large row count needs nine bits of word width.
  if (WORD_W < 9) begin : g_bad_width
    $error("Program word too narrow for the erasable row count.");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Address decode.

  region_e region;
  logic [15:0] ofs;
  word_t lookup;
  logic in_info;
  logic in_geom;

  // Sort the read address into its region and offset.
  always_comb begin
    in_info = (rd_cmd.addr >= INFO_BASE) && (rd_cmd.addr <= INFO_LAST);
    in_geom = (rd_cmd.addr >= GEOM_BASE) && (rd_cmd.addr <= GEOM_LAST);
    region = REG_NONE;
    ofs = 16'h0000;
    if (in_geom) begin
      region = REG_GEOM;
      ofs = rd_cmd.addr - GEOM_BASE;
    end else if (rd_cmd.addr >= SERIAL_BASE && rd_cmd.addr <= SERIAL_LAST) begin
      region = REG_SERIAL;
      ofs = rd_cmd.addr - SERIAL_BASE;
    end else if (rd_cmd.addr >= CUST_BASE && rd_cmd.addr <= CUST_LAST) begin
      region = REG_CUSTOMER;
      ofs = rd_cmd.addr - CUST_BASE;
    end else if (rd_cmd.addr >= TLOW_BASE && rd_cmd.addr <= TLOW_LAST) begin
      region = REG_TLOW;
      ofs = rd_cmd.addr - TLOW_BASE;
    end else if (rd_cmd.addr >= THIGH_BASE && rd_cmd.addr <= THIGH_LAST) begin
      region = REG_THIGH;
      ofs = rd_cmd.addr - THIGH_BASE;
    end else if (rd_cmd.addr >= ADC_REF_BASE && rd_cmd.addr <= ADC_REF_LAST) begin
      region = REG_ADC_REF;
      ofs = rd_cmd.addr - ADC_REF_BASE;
    end else if (rd_cmd.addr >= CMP_REF_BASE && rd_cmd.addr <= CMP_REF_LAST) begin
      region = REG_CMP_REF;
      ofs = rd_cmd.addr - CMP_REF_BASE;
    end else if (in_info) begin
      region = REG_RESERVED;
    end
  end

  // Pick the word; contents are constants so no path can alter them.
  always_comb begin
    lookup = RESERVED_WORD;
    unique case (region)
      REG_NONE: lookup = RESERVED_WORD;
      REG_RESERVED: lookup = RESERVED_WORD;
      REG_SERIAL: lookup = SERIAL_INIT[ofs[3:0]*WORD_W +: WORD_W];
      REG_CUSTOMER: lookup = CUST_INIT[ofs[2:0]*WORD_W +: WORD_W];
      REG_TLOW: lookup = TLOW_INIT[ofs[1:0]*WORD_W +: WORD_W];
      REG_THIGH: lookup = THIGH_INIT[ofs[1:0]*WORD_W +: WORD_W];
      REG_ADC_REF: lookup = ADC_REF_INIT[ofs[1:0]*WORD_W +: WORD_W];
      REG_CMP_REF: lookup = CMP_REF_INIT[ofs[1:0]*WORD_W +: WORD_W];
      REG_GEOM: begin
        unique case (ofs[2:0])
          ERASE_ROW_OFS: lookup = ERASE_ROW_WORDS;
          WRITE_LATCH_OFS: lookup = WRITE_LATCH_WORDS;
          ERASABLE_ROW_OFS: lookup = LARGE_VARIANT ? ROWS_LARGE : ROWS_SMALL;
          EEPROM_SIZE_OFS: lookup = EEPROM_BYTES;
          PIN_TOTAL_OFS: lookup = PIN_TOTAL;
          default: lookup = RESERVED_WORD;
        endcase
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registered read answer and write refusal.

  logic valid_r, valid_nxt;
  read_rsp_s rsp_r, rsp_nxt;
  logic err_r, err_nxt;
  logic prog_hit;

  // Any reader, tool or controller, gets the answer one cycle after its request.
  always_comb begin
    valid_nxt = rd_req;
    rsp_nxt = rsp_r;
    if (rd_req) begin
      rsp_nxt.data = lookup;
      rsp_nxt.hit = (region != REG_NONE);
    end
  end

  // Writes and row erases aimed at either range are refused; bulk erase skips them.
  always_comb begin
    prog_hit = ((prog_cmd.addr >= INFO_BASE) && (prog_cmd.addr <= INFO_LAST)) ||
               ((prog_cmd.addr >= GEOM_BASE) && (prog_cmd.addr <= GEOM_LAST));
    err_nxt = prog_req && prog_hit && (prog_cmd.kind != PROG_BULK_ERASE);
  end

  // Register the answer and the refusal pulse.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      valid_r <= 1'b0;
      rsp_r <= '0;
      err_r <= 1'b0;
    end else begin
      valid_r <= valid_nxt;
      rsp_r <= rsp_nxt;
      err_r <= err_nxt;
    end
  end

  assign rd_valid = valid_r;
  assign rd_rsp = rsp_r;
  assign prog_err = err_r;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions.

  // A read request at one address.
  sequence s_read_at(logic [15:0] a);
    rd_req && (rd_cmd.addr == a);
  endsequence

  // Two reads of the same address with a modification request between them.
  sequence s_read_mod_read;
    rd_req ##1 prog_req ##1 (rd_req && (rd_cmd.addr == $past(rd_cmd.addr, 2)));
  endsequence

  property p_range;
    @(posedge clk) disable iff (!rstn)
      rd_req |=> rd_valid &&
        (rd_rsp.hit == (($past(rd_cmd.addr) >= INFO_BASE && $past(rd_cmd.addr) <= INFO_LAST) ||
                        ($past(rd_cmd.addr) >= GEOM_BASE && $past(rd_cmd.addr) <= GEOM_LAST)));
  endproperty
  a_range: assert property (p_range) else $error("Range hit flag wrong.");

  property p_serial;
    @(posedge clk) disable iff (!rstn)
      s_read_at(16'h8104) |=> rd_rsp.data == SERIAL_INIT[4*WORD_W +: WORD_W];
  endproperty
  a_serial: assert property (p_serial) else $error("Serial word wrong.");

  property p_unchanged;
    @(posedge clk) disable iff (!rstn)
      s_read_mod_read |=> rd_valid && rd_rsp.data == $past(rd_rsp.data, 2) && rd_rsp.hit == $past(rd_rsp.hit, 2);
  endproperty
  a_unchanged: assert property (p_unchanged) else $error("Word changed after modify.");

  property p_customer;
    @(posedge clk) disable iff (!rstn)
      s_read_at(16'h8111) |=> rd_rsp.data == CUST_INIT[7*WORD_W +: WORD_W];
  endproperty
  a_customer: assert property (p_customer) else $error("Customer word wrong.");

  property p_bulk_ok;
    @(posedge clk) disable iff (!rstn)
      prog_req && prog_cmd.kind == PROG_BULK_ERASE |=> !prog_err;
  endproperty
  a_bulk_ok: assert property (p_bulk_ok) else $error("Bulk erase refused.");

  property p_tcal;
    @(posedge clk) disable iff (!rstn)
      s_read_at(16'h8112) ##1 s_read_at(16'h8117) |=>
        rd_rsp.data == THIGH_INIT[2*WORD_W +: WORD_W] && $past(rd_rsp.data) == TLOW_INIT[WORD_W-1:0];
  endproperty
  a_tcal: assert property (p_tcal) else $error("Temperature word wrong.");

  property p_ref;
    @(posedge clk) disable iff (!rstn)
      s_read_at(16'h811B) |=> rd_rsp.data == CMP_REF_INIT[WORD_W-1:0];
  endproperty
  a_ref: assert property (p_ref) else $error("Reference word wrong.");

  property p_refuse;
    @(posedge clk) disable iff (!rstn)
      prog_req && prog_cmd.kind == PROG_WRITE && prog_cmd.addr == 16'h8203 |=>
        prog_err ##1 (!prog_err || $past(prog_req));
  endproperty
  a_refuse: assert property (p_refuse) else $error("Geometry write not refused.");

  property p_geom;
    @(posedge clk) disable iff (!rstn)
      s_read_at(16'h8204) |=> rd_rsp.data == PIN_TOTAL && rd_rsp.hit;
  endproperty
  a_geom: assert property (p_geom) else $error("Pin count wrong.");

  property p_rows;
    @(posedge clk) disable iff (!rstn)
      s_read_at(16'h8202) |=> rd_rsp.data == (LARGE_VARIANT ? 14'h0100 : 14'h0080);
  endproperty
  a_rows: assert property (p_rows) else $error("Row count wrong.");

  property p_latency;
    @(posedge clk) disable iff (!rstn)
      !rd_req |=> !rd_valid;
  endproperty
  a_latency: assert property (p_latency) else $error("Answer without request.");

  property p_reserved;
    @(posedge clk) disable iff (!rstn)
      s_read_at(16'h8109) or s_read_at(16'h813F) |=> rd_rsp.data == RESERVED_WORD && rd_rsp.hit;
  endproperty
  a_reserved: assert property (p_reserved) else $error("Reserved word wrong.");

endmodule

// *** dv/info_reader.sv ***
`timescale 1ns/1ns
// Read-side partner: a controller or debug tool that issues single-word reads.
module info_reader
  import factory_info_pkg::*;
(
  // Read port toward the information region.
  output logic rd_req,
  output read_req_s rd_cmd,
  input wire logic rd_valid,
  input wire read_rsp_s rd_rsp,
  // Clock.
  input wire logic clk
);
  // Idle request lines at time zero.
  initial begin
    rd_req = 1'b0;
    rd_cmd = '0;
  end

  // One read, held for its take edge; the address is scrambled once released.
  task automatic read(input logic [15:0] a, output read_rsp_s r, output int lat);
    @(posedge clk);
    rd_req <= 1'b1;
    rd_cmd.addr <= a;
    @(posedge clk);
    rd_req <= 1'b0;
    rd_cmd.addr <= ~a;
    for (lat = 0; lat < 4; lat++) begin
      #1;
      if (rd_valid === 1'b1) break;
      @(posedge clk);
    end
    r = rd_rsp;
  endtask

  // Two reads on consecutive edges; each answer is taken while it stands.
  task automatic read_pair(input logic [15:0] a, input logic [15:0] b, output read_rsp_s ra, output read_rsp_s rb);
    @(posedge clk);
    rd_req <= 1'b1;
    rd_cmd.addr <= a;
    @(posedge clk);
    rd_cmd.addr <= b;
    #1;
    ra = rd_rsp;
    @(posedge clk);
    rd_req <= 1'b0;
    rd_cmd.addr <= ~b;
    #1;
    rb = rd_rsp;
  endtask
endmodule

// *** dv/tb.sv ***
`timescale 1ns/1ns
module tb;
  import factory_info_pkg::*;
  // Geometry contents chosen for this run.
  localparam logic [13:0] ERW = 14'h0020;
  localparam logic [13:0] WLC = 14'h0021;
  localparam logic [13:0] EEB = 14'h0081;
  localparam logic [13:0] PINS = 14'h001C;

  // Each stored word is its address scrambled, so a wrong word never matches.
  function automatic logic [125:0] fill(logic [13:0] b);
    for (int i = 0; i < 9; i++) fill[i*14+:14] = (b + 14'(i)) ^ 14'h1555;
  endfunction

  localparam logic [125:0] SER = fill(14'h0100);
  localparam logic [125:0] CUS = fill(14'h010A);
  localparam logic [125:0] TLO = fill(14'h0112);
  localparam logic [125:0] THI = fill(14'h0115);
  localparam logic [125:0] ADR = fill(14'h0118);
  localparam logic [125:0] CMR = fill(14'h011B);

  typedef struct packed {
    logic [15:0] addr;
    read_rsp_s exp;
  } row_s;

  logic clk;
  logic rstn;
  logic rd_req;
  read_req_s rd_cmd;
  logic rd_valid;
  read_rsp_s rd_rsp;
  read_rsp_s rsp_big;
  logic prog_req;
  prog_req_s prog_cmd;
  logic prog_err;
  int bad_count;
  int checked;
  row_s rows[$];
  logic pe[$];
  logic [15:0] pa[6] = '{16'h8100, 16'h810A, 16'h8204, 16'h8140, 16'h813F, 16'h8203};
  read_rsp_s r_a;
  read_rsp_s r_b;
  int lat_a;

  // Small and large variants share the read and modification traffic.
  factory_info_rom #(.SERIAL_INIT(SER), .CUST_INIT(CUS[111:0]), .TLOW_INIT(TLO[41:0]),
    .THIGH_INIT(THI[41:0]), .ADC_REF_INIT(ADR[41:0]), .CMP_REF_INIT(CMR[41:0]), .ERASE_ROW_WORDS(ERW),
    .WRITE_LATCH_WORDS(WLC), .EEPROM_BYTES(EEB), .PIN_TOTAL(PINS), .LARGE_VARIANT(1'b0)) factory_info_rom_i (
    .clk(clk), .rstn(rstn), .rd_req(rd_req), .rd_cmd(rd_cmd), .rd_valid(rd_valid), .rd_rsp(rd_rsp),
    .prog_req(prog_req), .prog_cmd(prog_cmd), .prog_err(prog_err));
  factory_info_rom #(.LARGE_VARIANT(1'b1)) factory_info_rom_big_i (
    .clk(clk), .rstn(rstn), .rd_req(rd_req), .rd_cmd(rd_cmd), .rd_valid(), .rd_rsp(rsp_big),
    .prog_req(prog_req), .prog_cmd(prog_cmd), .prog_err());
  info_reader info_reader_i (.rd_req(rd_req), .rd_cmd(rd_cmd), .rd_valid(rd_valid), .rd_rsp(rd_rsp), .clk(clk));

  ////////////////////////////////////////////////////////////////////////////////
  // Expected answer of any address.
  function automatic read_rsp_s expect_rd(logic [15:0] a);
    expect_rd.hit = (a >= INFO_BASE && a <= INFO_LAST) || (a >= GEOM_BASE && a <= GEOM_LAST);
    expect_rd.data = RESERVED_WORD;
    if ((a >= SERIAL_BASE && a <= SERIAL_LAST) || (a >= CUST_BASE && a <= CMP_REF_LAST)) begin
      expect_rd.data = a[13:0] ^ 14'h1555;
    end
    case (a)
      16'h8200: expect_rd.data = ERW;
      16'h8201: expect_rd.data = WLC;
      16'h8202: expect_rd.data = 14'h0080;
      16'h8203: expect_rd.data = EEB;
      16'h8204: expect_rd.data = PINS;
      default: ;
    endcase
  endfunction

  // Compare and count.
  task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("FAIL %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Print the counts and the verdict, then stop.
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // Read every row and compare word, hit flag and answer delay.
  task automatic run_rows;
    read_rsp_s r;
    int lat;
    foreach (rows[i]) begin
      info_reader_i.read(rows[i].addr, r, lat);
      check("latency", lat[15:0], 16'h0000);
      if (lat >= 4) wrap_up();
      check("read_rsp", 16'(r), 16'(rows[i].exp));
      if (rows[i].addr == 16'h8202) check("rows_large", 16'(rsp_big.data), 16'h0100);
    end
  endtask

  // Free-running clock.
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // Main sequence.
  initial begin
    rstn = 1'b0;
    prog_req = 1'b0;
    prog_cmd = '0;
    bad_count = 0;
    checked = 0;
    for (logic [15:0] a = 16'h80FE; a <= 16'h8141; a++) rows.push_back('{a, expect_rd(a)});
    for (logic [15:0] a = 16'h81FE; a <= 16'h8206; a++) rows.push_back('{a, expect_rd(a)});
    repeat (5) @(posedge clk);
    check("reset_rsp", {rd_valid, rd_rsp}, 16'h0000);
    check("reset_err", {15'h0, prog_err}, 16'h0000);
    rstn <= 1'b1;
    run_rows();
    // Writes, row erases and bulk erases, back to back, at six addresses in both ranges and just outside the information area.
    for (int i = 0; i < 19; i++) begin
      @(posedge clk);
      if (i < 18) begin
        prog_req <= 1'b1;
        prog_cmd <= '{prog_kind_e'(i / 6), pa[i % 6]};
        pe.push_back(i / 6 != 2 && (pa[i % 6] inside {[INFO_BASE:INFO_LAST], [GEOM_BASE:GEOM_LAST]}));
      end else prog_req <= 1'b0;
      #1;
      if (i >= 1) check("prog_err", {15'h0, prog_err}, {15'h0, pe[i-1]});
    end
    run_rows();
    // Back-to-back reads of the low and high temperature groups.
    info_reader_i.read_pair(16'h8112, 16'h8117, r_a, r_b);
    check("tcal_low", 16'(r_a), 16'(expect_rd(16'h8112)));
    check("tcal_high", 16'(r_b), 16'(expect_rd(16'h8117)));
    // A refused write falls between two reads of the same geometry word.
    fork
      begin
        info_reader_i.read(16'h8203, r_a, lat_a);
        info_reader_i.read(16'h8203, r_b, lat_a);
      end
      begin
        repeat (2) @(posedge clk);
        prog_req <= 1'b1;
        prog_cmd <= '{PROG_WRITE, 16'h8203};
        @(posedge clk);
        prog_req <= 1'b0;
        #1;
        check("geom_write_err", {15'h0, prog_err}, 16'h0001);
      end
    join
    check("geom_word", 16'(r_a), 16'(expect_rd(16'h8203)));
    check("geom_kept", 16'(r_b), 16'(expect_rd(16'h8203)));
    // Reset in mid-run clears the held answer.
    @(posedge clk);
    rstn <= 1'b0;
    #1;
    check("mid_reset_rsp", {rd_valid, rd_rsp}, 16'h0000);
    check("mid_reset_err", {15'h0, prog_err}, 16'h0000);
    @(posedge clk);
    rstn <= 1'b1;
    // Reads work again once reset is released.
    info_reader_i.read(16'h8202, r_a, lat_a);
    check("after_reset", 16'(r_a), 16'(expect_rd(16'h8202)));
    wrap_up();
  end
endmodule
